// file: rtl/fll_params.svh
// Register offsets, field positions, reset values and encodings for the log decoder.
`ifndef FLL_PARAMS_SVH
`define FLL_PARAMS_SVH

`define FLL_OFS_WORD1 5'h00
`define FLL_OFS_WORD2 5'h04
`define FLL_OFS_OPND 5'h08
`define FLL_OFS_CTRL 5'h0C
`define FLL_OFS_DEC 5'h10
`define FLL_OFS_FPSR 5'h14

`define FLL_F_LINE 4'hF
`define FLL_OP_LOG10 7'h15
`define FLL_OP_LOG2 7'h16
`define FLL_RST_CPID 3'h1
`define FLL_CTRL_EXEC 8

`define FLL_OPND_SIGN 0
`define FLL_OPND_ZERO 1
`define FLL_OPND_INF 2
`define FLL_OPND_NAN 3
`define FLL_OPND_SIGNALLING_NAN_FLAG 4
`define FLL_OPND_DECINX 5
`define FLL_OPND_RESINX 6
`define FLL_OPND_RESNEG 7
`define FLL_OPND_RESZERO 8

`define FLL_FMT_LONG 3'h0
`define FLL_FMT_SINGLE 3'h1
`define FLL_FMT_EXT 3'h2
`define FLL_FMT_PACKED 3'h3
`define FLL_FMT_WORD 3'h4
`define FLL_FMT_DOUBLE 3'h5
`define FLL_FMT_BYTE 3'h6

`endif

// file: rtl/fll_pkg.sv
// Types shared by the log decoder: addressing modes, result classes, decode and status records.
package fll_pkg;

   typedef enum logic [3:0] {
      FLL_EA_DREG = 4'h0, FLL_EA_IND = 4'h1, FLL_EA_POSTINC = 4'h2, FLL_EA_PREDEC = 4'h3,
      FLL_EA_DISP16 = 4'h4, FLL_EA_INDEX = 4'h5, FLL_EA_ABS_SHORT = 4'h6, FLL_EA_ABS_LONG = 4'h7,
      FLL_EA_IMM = 4'h8, FLL_EA_PC_DISP = 4'h9, FLL_EA_PC_INDEX = 4'hA, FLL_EA_NONE = 4'hB,
      FLL_EA_BAD = 4'hC
   } fll_ea_t;

   typedef enum logic [2:0] {
      FLL_RES_NONE = 3'h0, FLL_RES_LOG = 3'h1, FLL_RES_NAN = 3'h2,
      FLL_RES_NEG_INF = 3'h3, FLL_RES_POS_INF = 3'h4
   } fll_res_t;

   typedef struct packed {
      logic accepted;
      logic log_base_two_op;
      logic log_base_ten_op;
      logic mem_source;
      logic same_reg;
      logic needs_convert;
      fll_ea_t ea_mode;
      logic [2:0] ea_reg;
      logic [2:0] fmt;
      logic [2:0] src_reg;
      logic [2:0] dst_reg;
      fll_res_t result;
   } fll_dec_t;

   typedef struct packed {
      logic [3:0] cc;
      logic [7:0] quotient;
      logic branch_unordered_flag;
      logic signalling_nan_flag;
      logic invalid_operation_flag;
      logic overflow_flag;
      logic underflow_flag;
      logic divide_by_zero_flag;
      logic result_inexact_flag;
      logic decimal_input_inexact_flag;
      logic [4:0] accrued;
      logic [2:0] spare;
   } fll_fpsr_t;

endpackage : fll_pkg

// file: rtl/fll_log_decode.sv
// Avalon-MM decoder and status-flag logic for the base-two and base-ten logarithm instructions.
//
// The Avalon-MM register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "fll_params.svh"

//////////////////////////////////////////////////////////////////////////////////////////////////
// How it works
// RL1 - Act only when the coprocessor ID field matches the programmed unit ID.
// RL2 - Word one is 1111, ID, 000; opmodes 0010101 base ten, 0010110 base two.
// RL3 - Select bit 0 means register to register from a data register.
// RL4 - Select bit 1 fetches the source through the effective address into a register.
// RL5 - The issuer zeroes the address field for register operations; it is ignored.
// RL6 - Memory sources decode the address mode bits into their addressing forms.
// RL7 - Mode 111 decodes register 000,001,100,010,011 as absolute, immediate, PC forms.
// RL8 - Data register direct only for byte, word, long or single; address direct invalid.
// RL9 - With select bit 0 the source field names the source data register.
// RL10 - With memory sources the source field names one of seven formats.
// RL11 - Equal source and destination registers read and write that same register.
// RL12 - Convert non-extended sources to extended, then place the log in the destination.
// RL13 - Base two computes log two; positive infinity gives positive infinity.
// RL14 - Negative or negative infinity source gives NaN and sets invalid operation.
// RL15 - Zero of either sign gives negative infinity and sets divide by zero.
// RL16 - Inputs below zero are undefined and signal invalid operation.
// RL17 - NaN sources take the general NaN handling with the signalling NaN flag.
// RL18 - Decimal input inexact only for inexact packed sources; cleared otherwise.
// RL19 - Condition codes follow the result by the ordinary testing rules.
// RL20 - Accrued byte gathers the current exception flags, IEEE style.
// RL21 - Clear unordered, overflow and underflow; quotient byte stays unchanged.
//////////////////////////////////////////////////////////////////////////////////////////////////

module fll_log_decode
   import fll_pkg::*;
#(
   parameter int ADDR_W = 5
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output fll_dec_t dec_out,
   output fll_fpsr_t fpsr_out,
   output logic done_pulse
);

   //////////////////////////////////////////////////////////////////////////////////////////////
   // Functions.

   function automatic logic [31:0] fll_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] be);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            res[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return res;
   endfunction : fll_merge

   function automatic logic fll_hit(input logic [ADDR_W-1:0] addr, input logic [4:0] ofs);
      return addr == ofs[ADDR_W-1:0];
   endfunction : fll_hit

   //////////////////////////////////////////////////////////////////////////////////////////////
   // Bus slave. One wait state: the read word is captured on the first edge of the request,
   // so it already stands when waitrequest is seen low on the second.

   logic [15:0] word1_ff;
   logic [15:0] word2_ff;
   logic [8:0] opnd_ff;
   logic [2:0] cpid_ff;
   logic waitrequest_ff;
   logic [31:0] readdata_ff;
   logic done_ff;
   fll_dec_t dec_ff;
   fll_fpsr_t fpsr_ff;
   logic req;
   logic take;
   logic wr_take;
   logic exec;
   logic [31:0] rd_mux;
   logic [31:0] mrg_word1;
   logic [31:0] mrg_word2;
   logic [31:0] mrg_opnd;
   logic [31:0] mrg_ctrl;
   logic [31:0] mrg_fpsr;

   assign req = avs_read | avs_write;
   assign take = req & ~waitrequest_ff;
   assign wr_take = take & avs_write;
   assign exec = wr_take & fll_hit(avs_address, `FLL_OFS_CTRL) & avs_byteenable[1]
                 & avs_writedata[`FLL_CTRL_EXEC];

   // Merged words are formed at full bus width and cut to each register's width on purpose.
   assign mrg_word1 = fll_merge({16'h0000, word1_ff}, avs_writedata, avs_byteenable);
   assign mrg_word2 = fll_merge({16'h0000, word2_ff}, avs_writedata, avs_byteenable);
   assign mrg_opnd = fll_merge({23'h00_0000, opnd_ff}, avs_writedata, avs_byteenable);
   assign mrg_ctrl = fll_merge({29'h0000_0000, cpid_ff}, avs_writedata, avs_byteenable);
   assign mrg_fpsr = fll_merge({4'h0, fpsr_ff}, avs_writedata, avs_byteenable);

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         waitrequest_ff <= 1'b1;
      end else begin
         waitrequest_ff <= ~(req & waitrequest_ff);
      end
   end

   always_comb begin
      rd_mux = 32'h0000_0000;
      if (fll_hit(avs_address, `FLL_OFS_WORD1)) begin
         rd_mux = {16'h0000, word1_ff};
      end else if (fll_hit(avs_address, `FLL_OFS_WORD2)) begin
         rd_mux = {16'h0000, word2_ff};
      end else if (fll_hit(avs_address, `FLL_OFS_OPND)) begin
         rd_mux = {23'h00_0000, opnd_ff};
      end else if (fll_hit(avs_address, `FLL_OFS_CTRL)) begin
         rd_mux = {29'h0000_0000, cpid_ff};
      end else if (fll_hit(avs_address, `FLL_OFS_DEC)) begin
         rd_mux = {7'h00, dec_ff};
      end else if (fll_hit(avs_address, `FLL_OFS_FPSR)) begin
         rd_mux = {4'h0, fpsr_ff};
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         readdata_ff <= 32'h0000_0000;
      end else if (avs_read & waitrequest_ff) begin
         readdata_ff <= rd_mux;
      end
   end

   // Software-held instruction words, operand class and unit ID.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         word1_ff <= 16'h0000;
         word2_ff <= 16'h0000;
         opnd_ff <= 9'h000;
         cpid_ff <= `FLL_RST_CPID;
      end else if (wr_take) begin
         if (fll_hit(avs_address, `FLL_OFS_WORD1)) begin
            word1_ff <= mrg_word1[15:0];
         end
         if (fll_hit(avs_address, `FLL_OFS_WORD2)) begin
            word2_ff <= mrg_word2[15:0];
         end
         if (fll_hit(avs_address, `FLL_OFS_OPND)) begin
            opnd_ff <= mrg_opnd[8:0];
         end
         if (fll_hit(avs_address, `FLL_OFS_CTRL)) begin
            cpid_ff <= mrg_ctrl[2:0];
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////////////////////////
   // Instruction decode.

   logic rm;
   logic [2:0] spec;
   logic [2:0] ea_m;
   logic [2:0] ea_r;
   logic is_ten;
   logic is_two;
   logic fmt_ok;
   logic ea_ok;
   logic small_fmt;
   fll_ea_t ea_dec;
   fll_dec_t nxt_dec;

   assign rm = word2_ff[14];
   assign spec = word2_ff[12:10];
   assign ea_m = word1_ff[5:3];
   assign ea_r = word1_ff[2:0];
   assign is_ten = word2_ff[6:0] == `FLL_OP_LOG10; // [RL2]
   assign is_two = word2_ff[6:0] == `FLL_OP_LOG2; // [RL2]
   assign fmt_ok = ~rm | (spec <= `FLL_FMT_BYTE); // [RL10]
   assign small_fmt = (spec == `FLL_FMT_BYTE) | (spec == `FLL_FMT_WORD)
                      | (spec == `FLL_FMT_LONG) | (spec == `FLL_FMT_SINGLE); // [RL8]

   // The address field is not looked at for register sources, so junk there is harmless.
   always_comb begin
      ea_dec = FLL_EA_NONE; // [RL5]
      if (rm) begin
         case (ea_m) // [RL6]
            3'h0: ea_dec = small_fmt ? FLL_EA_DREG : FLL_EA_BAD; // [RL8]
            3'h1: ea_dec = FLL_EA_BAD; // [RL8]
            3'h2: ea_dec = FLL_EA_IND;
            3'h3: ea_dec = FLL_EA_POSTINC;
            3'h4: ea_dec = FLL_EA_PREDEC;
            3'h5: ea_dec = FLL_EA_DISP16;
            3'h6: ea_dec = FLL_EA_INDEX;
            3'h7: begin
               case (ea_r) // [RL7]
                  3'h0: ea_dec = FLL_EA_ABS_SHORT;
                  3'h1: ea_dec = FLL_EA_ABS_LONG;
                  3'h2: ea_dec = FLL_EA_PC_DISP;
                  3'h3: ea_dec = FLL_EA_PC_INDEX;
                  3'h4: ea_dec = FLL_EA_IMM;
                  default: ea_dec = FLL_EA_BAD;
               endcase
            end
            default: ea_dec = FLL_EA_BAD;
         endcase
      end
   end

   assign ea_ok = ea_dec != FLL_EA_BAD;

   //////////////////////////////////////////////////////////////////////////////////////////////
   // Special-operand classification and status flags.

   logic s_neg;
   logic s_zero;
   logic s_inf;
   logic s_nan;
   fll_fpsr_t nxt_fpsr;

   assign s_nan = opnd_ff[`FLL_OPND_NAN];
   assign s_zero = opnd_ff[`FLL_OPND_ZERO] & ~s_nan;
   assign s_inf = opnd_ff[`FLL_OPND_INF] & ~s_nan;
   assign s_neg = opnd_ff[`FLL_OPND_SIGN] & ~s_nan & ~s_zero;

   always_comb begin
      nxt_dec = '0;
      nxt_dec.accepted = (word1_ff[15:12] == `FLL_F_LINE) & (word1_ff[8:6] == 3'h0) // [RL2]
                         & (word1_ff[11:9] == cpid_ff) // [RL1]
                         & ~word2_ff[15] & ~word2_ff[13] & (is_ten | is_two) & fmt_ok & ea_ok;
      nxt_dec.log_base_two_op = is_two;
      nxt_dec.log_base_ten_op = is_ten;
      nxt_dec.mem_source = rm; // [RL3] [RL4]
      nxt_dec.ea_mode = ea_dec;
      nxt_dec.ea_reg = rm ? ea_r : 3'h0;
      nxt_dec.fmt = rm ? spec : `FLL_FMT_EXT; // [RL10]
      nxt_dec.src_reg = rm ? 3'h0 : spec; // [RL9]
      nxt_dec.dst_reg = word2_ff[9:7]; // [RL12]
      nxt_dec.same_reg = ~rm & (spec == word2_ff[9:7]); // [RL11]
      nxt_dec.needs_convert = rm & (spec != `FLL_FMT_EXT); // [RL12]
      if (s_nan) begin
         nxt_dec.result = FLL_RES_NAN; // [RL17]
      end else if (s_neg) begin
         nxt_dec.result = FLL_RES_NAN; // [RL14] [RL16]
      end else if (s_zero) begin
         nxt_dec.result = FLL_RES_NEG_INF; // [RL15]
      end else if (s_inf) begin
         nxt_dec.result = FLL_RES_POS_INF; // [RL13]
      end else begin
         nxt_dec.result = FLL_RES_LOG; // [RL13]
      end
      if (!nxt_dec.accepted) begin
         nxt_dec.result = FLL_RES_NONE;
      end
   end

   always_comb begin
      nxt_fpsr = fpsr_ff; // [RL21]
      nxt_fpsr.branch_unordered_flag = 1'b0; // [RL21]
      nxt_fpsr.overflow_flag = 1'b0; // [RL21]
      nxt_fpsr.underflow_flag = 1'b0; // [RL21]
      nxt_fpsr.signalling_nan_flag = s_nan & opnd_ff[`FLL_OPND_SIGNALLING_NAN_FLAG]; // [RL17]
      nxt_fpsr.invalid_operation_flag = s_neg; // [RL14] [RL16]
      nxt_fpsr.divide_by_zero_flag = s_zero; // [RL15]
      nxt_fpsr.result_inexact_flag = ~s_nan & ~s_neg & ~s_zero & ~s_inf & opnd_ff[`FLL_OPND_RESINX];
      nxt_fpsr.decimal_input_inexact_flag = rm & (spec == `FLL_FMT_PACKED)
                                            & opnd_ff[`FLL_OPND_DECINX]; // [RL18]
      // Order of codes is negative, zero, infinity, NaN.
      case (nxt_dec.result) // [RL19]
         FLL_RES_NAN: nxt_fpsr.cc = 4'h1;
         FLL_RES_NEG_INF: nxt_fpsr.cc = 4'hA;
         FLL_RES_POS_INF: nxt_fpsr.cc = 4'h2;
         FLL_RES_LOG: nxt_fpsr.cc = {opnd_ff[`FLL_OPND_RESNEG], opnd_ff[`FLL_OPND_RESZERO], 2'h0};
         default: nxt_fpsr.cc = fpsr_ff.cc;
      endcase
      // Accrued: invalid, overflow, underflow, divide by zero, inexact; sticky until written.
      nxt_fpsr.accrued = fpsr_ff.accrued | { // [RL20]
         nxt_fpsr.branch_unordered_flag | nxt_fpsr.signalling_nan_flag | nxt_fpsr.invalid_operation_flag,
         nxt_fpsr.overflow_flag,
         nxt_fpsr.underflow_flag & nxt_fpsr.result_inexact_flag,
         nxt_fpsr.divide_by_zero_flag,
         nxt_fpsr.result_inexact_flag | nxt_fpsr.decimal_input_inexact_flag | nxt_fpsr.overflow_flag};
      nxt_fpsr.spare = 3'h0;
   end

   //////////////////////////////////////////////////////////////////////////////////////////////
   // State update on execute. A rejected instruction leaves the status register alone.

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         dec_ff <= '0;
         done_ff <= 1'b0;
      end else begin
         done_ff <= exec;
         if (exec) begin
            dec_ff <= nxt_dec;
         end
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         fpsr_ff <= '0;
      end else if (exec && nxt_dec.accepted) begin
         fpsr_ff <= nxt_fpsr; // [RL1]
      end else if (wr_take && fll_hit(avs_address, `FLL_OFS_FPSR)) begin
         fpsr_ff <= mrg_fpsr[27:0];
      end
   end

   assign avs_readdata = readdata_ff;
   assign avs_waitrequest = waitrequest_ff;
   assign dec_out = dec_ff;
   assign fpsr_out = fpsr_ff;
   assign done_pulse = done_ff;

endmodule : fll_log_decode

// file: test/fll_host_model.sv
// Host core model that issues logarithm instructions over Avalon-MM.
`timescale 1ns/1ps
`include "fll_params.svh"
module fll_host_model #(
   parameter int ADDR_W = 5
) (
   input wire logic clock,
   output logic [ADDR_W-1:0] avs_address,
   output logic avs_read,
   output logic avs_write,
   output logic [31:0] avs_writedata,
   output logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest
);
   initial begin
      avs_address = '0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hF;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // The request is held until waitrequest is sampled low; no latency is assumed.
   task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd, output logic [31:0] rd);
      @(posedge clock);
      avs_read <= !wr;
      avs_write <= wr;
      avs_address <= a;
      avs_writedata <= wd;
      do @(posedge clock); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      avs_writedata <= ~wd;
   endtask : xfer

   task automatic issue(input logic [15:0] w1, input logic [15:0] w2, input logic [8:0] op,
         input logic [2:0] id, output logic [15:0] ws);
      logic [31:0] rd;
      ws = w2[14] ? w1 : {w1[15:6], 6'h00};
      xfer(1'b1, `FLL_OFS_WORD1, {16'h0000, ws}, rd);
      xfer(1'b1, `FLL_OFS_WORD2, {16'h0000, w2}, rd);
      xfer(1'b1, `FLL_OFS_OPND, {23'h000000, op}, rd);
      xfer(1'b1, `FLL_OFS_CTRL, {23'h000000, 1'b1, 5'h00, id}, rd);
   endtask : issue
endmodule : fll_host_model

// file: test/fll_log_decode_checker.sv
// Port assertions for the log decoder.
`timescale 1ns/1ps
`include "fll_params.svh"
module fll_log_decode_checker
   import fll_pkg::*;
#(
   parameter int ADDR_W = 5
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input fll_dec_t dec_out,
   input fll_fpsr_t fpsr_out,
   input wire logic done_pulse
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   wire logic exec_hit = avs_write && !avs_waitrequest && avs_address == `FLL_OFS_CTRL
      && avs_byteenable[1] && avs_writedata[`FLL_CTRL_EXEC];
   sequence s_pulse; done_pulse ##1 !done_pulse; endsequence
   sequence s_ok; done_pulse && dec_out.accepted; endsequence

   AST_WAIT_ONE: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus answer late");
   AST_WAIT_BACK: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("wait low too long");
   AST_DONE: assert property (exec_hit |=> s_pulse) else $error("done pulse missing");
   AST_DONE_CAUSE: assert property (done_pulse |-> $past(exec_hit)) else $error("stray done");
   AST_KIND: assert property (s_ok |-> dec_out.log_base_two_op != dec_out.log_base_ten_op)
      else $error("opmode kind wrong");
   AST_REG_SRC: assert property (s_ok |-> dec_out.mem_source || (dec_out.ea_mode == FLL_EA_NONE
      && dec_out.same_reg == (dec_out.src_reg == dec_out.dst_reg))) else $error("register source wrong");
   AST_DZ: assert property (s_ok |-> fpsr_out.divide_by_zero_flag == (dec_out.result == FLL_RES_NEG_INF))
      else $error("divide flag wrong");
   AST_INV: assert property (s_ok |-> !fpsr_out.invalid_operation_flag || dec_out.result == FLL_RES_NAN)
      else $error("invalid flag wrong");
   AST_CLR: assert property (s_ok |-> !(fpsr_out.branch_unordered_flag || fpsr_out.overflow_flag
      || fpsr_out.underflow_flag)) else $error("flag not cleared");
   AST_QUOT: assert property (exec_hit |=> fpsr_out.quotient == $past(fpsr_out.quotient))
      else $error("quotient changed");
   AST_REFUSE: assert property (exec_hit |=> dec_out.accepted || fpsr_out == $past(fpsr_out))
      else $error("refused op touched status");
endmodule : fll_log_decode_checker

bind fll_log_decode fll_log_decode_checker #(.ADDR_W(ADDR_W)) u_chk (.clock(clock), .rst(rst),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
   .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .dec_out(dec_out), .fpsr_out(fpsr_out), .done_pulse(done_pulse));

// file: test/fll_log_decode_test.sv
// Self-checking bench for the log decoder.
`timescale 1ns/1ps
`include "fll_params.svh"
module fll_log_decode_test
   import fll_pkg::*;
;
   logic clock;
   logic rst = 1'b1;
   logic [4:0] avs_address;
   logic avs_read, avs_write, avs_waitrequest, done_pulse;
   logic [31:0] avs_writedata, avs_readdata;
   logic [3:0] avs_byteenable;
   fll_dec_t dec_out;
   fll_fpsr_t fpsr_out, exp_f;
   logic [2:0] cur_id;
   int miscompares = 0;
   int comparisons = 0;
   int cycles = 0;

   fll_log_decode #(.ADDR_W(5)) DUT (.clock(clock), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .dec_out(dec_out), .fpsr_out(fpsr_out),
      .done_pulse(done_pulse));
   fll_host_model #(.ADDR_W(5)) u_host (.clock(clock), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
      comparisons++;
      if (seen !== want) begin
         miscompares++;
         $display("wrong value at %0t: %s", $time, what);
      end
   endtask : check

   task automatic complete_run;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : complete_run

   // A hung handshake would otherwise stall the run forever.
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         complete_run();
      end
   end

   function automatic logic [31:0] key(input fll_fpsr_t f);
      return {7'h00, f.accrued, f.cc, f.quotient, f.branch_unordered_flag, f.signalling_nan_flag, f.invalid_operation_flag,
         f.overflow_flag, f.underflow_flag, f.divide_by_zero_flag, f.result_inexact_flag, f.decimal_input_inexact_flag};
   endfunction : key

   function automatic void predict(input logic [15:0] w1, input logic [15:0] w2, input logic [8:0] op,
         output fll_dec_t d, inout fll_fpsr_t f);
      logic m;
      logic [2:0] fm, md;
      fll_ea_t m7[5];
      m7 = '{FLL_EA_ABS_SHORT, FLL_EA_ABS_LONG, FLL_EA_PC_DISP, FLL_EA_PC_INDEX, FLL_EA_IMM};
      m = w2[14];
      fm = w2[12:10];
      md = w1[5:3];
      d = '0;
      d.accepted = w1[15:12] == `FLL_F_LINE && w1[11:9] == cur_id && w1[8:6] == 3'h0 && !w2[15] && !w2[13]
         && (w2[6:0] == `FLL_OP_LOG10 || w2[6:0] == `FLL_OP_LOG2);
      if (m) d.accepted &= fm != 3'h7 && md != 3'h1 && (md != 3'h0 || fm inside {3'h0, 3'h1, 3'h4, 3'h6})
         && (md != 3'h7 || w1[2:0] < 3'h5);
      d.result = FLL_RES_NONE;
      if (!d.accepted) return;
      d.log_base_two_op = w2[6:0] == `FLL_OP_LOG2;
      d.log_base_ten_op = w2[6:0] == `FLL_OP_LOG10;
      d.mem_source = m;
      d.same_reg = !m && fm == w2[9:7];
      d.needs_convert = m && fm != `FLL_FMT_EXT;
      d.ea_mode = FLL_EA_NONE;
      if (m && md == 3'h0) d.ea_mode = FLL_EA_DREG;
      if (m && md > 3'h1 && md < 3'h7) d.ea_mode = fll_ea_t'({1'b0, md} - 4'h1);
      if (m && md == 3'h7) d.ea_mode = m7[w1[2:0]];
      d.ea_reg = m ? w1[2:0] : 3'h0;
      d.fmt = m ? fm : `FLL_FMT_EXT;
      d.src_reg = m ? 3'h0 : fm;
      d.dst_reg = w2[9:7];
      {f.branch_unordered_flag, f.signalling_nan_flag, f.invalid_operation_flag, f.overflow_flag} = 4'h0;
      {f.underflow_flag, f.divide_by_zero_flag, f.result_inexact_flag} = 3'h0;
      f.decimal_input_inexact_flag = m && fm == `FLL_FMT_PACKED && op[5];
      if (op[3]) begin
         d.result = FLL_RES_NAN;
         f.signalling_nan_flag = op[4];
         f.cc = 4'h1;
      end else if (op[1]) begin
         d.result = FLL_RES_NEG_INF;
         f.divide_by_zero_flag = 1'b1;
         f.cc = 4'hA;
      end else if (op[0]) begin
         d.result = FLL_RES_NAN;
         f.invalid_operation_flag = 1'b1;
         f.cc = 4'h1;
      end else if (op[2]) begin
         d.result = FLL_RES_POS_INF;
         f.cc = 4'h2;
      end else begin
         d.result = FLL_RES_LOG;
         f.result_inexact_flag = op[6];
         f.cc = {op[7], op[8], 2'h0};
      end
      f.accrued |= {f.signalling_nan_flag | f.invalid_operation_flag, 2'h0, f.divide_by_zero_flag,
         f.result_inexact_flag | f.decimal_input_inexact_flag};
   endfunction : predict

   task automatic run_op(input logic [15:0] w1, input logic [15:0] w2, input logic [8:0] op, input logic [2:0] nid);
      logic [15:0] ws;
      fll_dec_t d;
      u_host.issue(w1, w2, op, nid, ws);
      predict(ws, w2, op, d, exp_f);
      cur_id = nid;
      @(negedge clock);
      check(32'(done_pulse), 32'h1, "done");
      check(32'(dec_out.result), 32'(d.result), "result");
      check(d.accepted ? 32'(dec_out) : 32'(dec_out.accepted), d.accepted ? 32'(d) : 32'h0, "decode");
      check(key(fpsr_out), key(exp_f), "status");
   endtask : run_op

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [31:0] rd, r, s;
      logic [15:0] w1, w2;
      logic [47:0] t[10];
      t = '{48'h1F23F0D96002, 48'h1F23C4C950E0, 48'h1F2014816000, 48'h1F2094415000, 48'h1F2105C15000,
         48'h1F2000516005, 48'h1F2000515018, 48'h1F2000516004, 48'h2F4000516000, 48'h1F4000516100};
      cur_id = 3'h1;
      exp_f = '0;
      s = $urandom(5801);
      repeat (6) @(posedge clock);
      rst <= 1'b0;
      check(32'(avs_waitrequest), 32'h1, "idle wait");
      check(32'(dec_out) | key(fpsr_out) | 32'(done_pulse), 32'h0, "reset outputs");
      u_host.xfer(1'b0, `FLL_OFS_CTRL, 32'h0, rd);
      check(rd, 32'h1, "unit id");
      $display("test reset done");
      u_host.xfer(1'b1, `FLL_OFS_WORD1, 32'hFFFFABCD, rd);
      u_host.xfer(1'b0, `FLL_OFS_WORD1, 32'h0, rd);
      check(rd, 32'h0000ABCD, "word readback");
      u_host.xfer(1'b1, 5'h1C, 32'h5A5A5A5A, rd);
      u_host.xfer(1'b0, 5'h1C, 32'h0, rd);
      check(rd, 32'h0, "unmapped read");
      u_host.xfer(1'b1, `FLL_OFS_FPSR, 32'h00A5_0000, rd);
      u_host.xfer(1'b0, `FLL_OFS_FPSR, 32'h0, rd);
      check(rd, 32'h00A5_0000, "status write");
      exp_f.quotient = 8'hA5;
      $display("test bus done");
      foreach (t[i]) run_op(t[i][43:28], t[i][27:12], t[i][8:0], t[i][46:44]);
      $display("test corners done");
      for (int i = 0; i < 150; i++) begin
         r = $urandom;
         s = $urandom;
         w1 = {4'hF, cur_id, 3'h0, r[5:0]};
         if (r[8:6] == 3'h0) w1[11:9] = r[11:9];
         if (r[14:12] == 3'h0) w1[8:6] = r[17:15];
         if (r[20:18] == 3'h0) w1[15:12] = r[24:21];
         w2 = {1'b0, s[0], 1'b0, s[3:1], s[6:4], s[7] ? `FLL_OP_LOG2 : `FLL_OP_LOG10};
         if (s[10:8] == 3'h0) w2[15:13] = s[13:11];
         if (s[16:14] == 3'h0) w2[6:0] = s[23:17];
         run_op(w1, w2, {r[31:28], s[31:27]}, r[27:25] == 3'h0 ? r[30:28] : cur_id);
      end
      $display("test random done");
      complete_run();
   end
endmodule : fll_log_decode_test
